// ---- design/tdcu_defines.svh ----
// Register map, field positions, reset values and rate counts of the timer unit.
`ifndef TDCU_DEFINES_SVH
`define TDCU_DEFINES_SVH

`define TDCU_A_CTRL      8'h88
`define TDCU_A_MODE      8'h89
`define TDCU_A_TLA       8'h8A
`define TDCU_A_TLB       8'h8B
`define TDCU_A_THA       8'h8C
`define TDCU_A_THB       8'h8D
`define TDCU_A_CLK       8'h8E

`define TDCU_RST_CTRL    8'h00
`define TDCU_RST_MODE    8'h00
`define TDCU_RST_CLK     8'h01
`define TDCU_RST_CNT     8'h00

`define TDCU_B_TYP_A     0
`define TDCU_B_IRQ_A     1
`define TDCU_B_RUN_A     4
`define TDCU_B_OVF_A     5
`define TDCU_STRIDE      2

`define TDCU_F_MODE      1:0
`define TDCU_B_CT        2
`define TDCU_B_GATE      3
`define TDCU_NIB_B       4

`define TDCU_B_PRE_A     3
`define TDCU_B_PRE_B     4
`define TDCU_CLK_MASK    8'h3F

`define TDCU_FAST_LAST   2'h3
`define TDCU_SLOW_LAST   4'hB

`define TDCU_NPINS       4
`define TDCU_P_EVT_A     0
`define TDCU_P_EVT_B     1
`define TDCU_P_IRQ_A     2
`define TDCU_P_IRQ_B     3

`endif

// ---- design/tdcu_pkg.sv ----
// Types shared by the timer unit files.
package tdcu_pkg;

  typedef enum logic [1:0] {
    TDCU_M13   = 2'h0,
    TDCU_M16   = 2'h1,
    TDCU_M8R   = 2'h2,
    TDCU_SPLIT = 2'h3
  } tdcu_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } tdcu_sfr_req_s;

  typedef struct packed {
    logic [7:0] th;
    logic [7:0] tl;
    logic       ovf;
  } tdcu_step_s;

endpackage

// ---- design/tdcu_pin_sync.sv ----
// Two-stage synchroniser and falling-edge detector for the unit's pins.
`timescale 1ns/1ps
`include "tdcu_defines.svh"
module tdcu_pin_sync (
  // Clock and reset.
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  // Raw pins and their synchronised view.
  input  wire logic [`TDCU_NPINS-1:0]  i_pins,
  output logic      [`TDCU_NPINS-1:0]  o_level,
  output logic      [`TDCU_NPINS-1:0]  o_fall
);

  logic [`TDCU_NPINS-1:0] s1_r;
  logic [`TDCU_NPINS-1:0] s2_r;
  logic [`TDCU_NPINS-1:0] s3_r;
  logic [`TDCU_NPINS-1:0] fall_r;

  genvar gi;
  generate
    for (gi = 0; gi < `TDCU_NPINS; gi++) begin : g_pin
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          s1_r[gi]   <= 1'b1;
          s2_r[gi]   <= 1'b1;
          s3_r[gi]   <= 1'b1;
          fall_r[gi] <= 1'b0;
        end else begin
          s1_r[gi]   <= i_pins[gi];
          s2_r[gi]   <= s1_r[gi];
          s3_r[gi]   <= s2_r[gi];
          fall_r[gi] <= s3_r[gi] & ~s2_r[gi];
        end
      end

      fall_prior_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_fall[gi] |-> !$past(o_level[gi]) && !$past(o_fall[gi]))
        else $error("edge pulse without a low level before it");
    end
  endgenerate

  assign o_level = s2_r;
  assign o_fall  = fall_r;

endmodule

// ---- design/tdcu_tick_gen.sv ----
// Divides the core clock into increment ticks every 4 and every 12 cycles.
`timescale 1ns/1ps
`include "tdcu_defines.svh"
module tdcu_tick_gen (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Rate ticks, one cycle each.
  output logic      o_tick_fast,
  output logic      o_tick_slow
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       fast_r;
  logic       slow_r;

  assign cnt_nxt = (cnt_r == `TDCU_SLOW_LAST) ? 4'h0 : cnt_r + 4'h1;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r  <= 4'h0;
      fast_r <= 1'b0;
      slow_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      fast_r <= (cnt_r[1:0] == `TDCU_FAST_LAST);
      slow_r <= (cnt_r == `TDCU_SLOW_LAST);
    end
  end

  assign o_tick_fast = fast_r;
  assign o_tick_slow = slow_r;

  slow_period_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tick_slow |=> !o_tick_slow [*8] ##1 !o_tick_slow [*3] ##1 o_tick_slow)
    else $error("slow tick period is not twelve clocks");

  fast_period_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tick_fast |=> !o_tick_fast [*3] ##1 o_tick_fast)
    else $error("fast tick period is not four clocks");

endmodule

// ---- design/tdcu_timer_unit.sv ----
// Two timer/counters with their control, mode, rate and external interrupt flags.
`timescale 1ns/1ps
`include "tdcu_defines.svh"
module tdcu_timer_unit
  import tdcu_pkg::*;
(
  // Clock and reset.
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // Special function register port.
  input  wire tdcu_sfr_req_s i_sfr,
  output logic               o_sfr_sel,
  output logic [7:0]         o_sfr_rdata,
  // Interrupt vector acknowledges.
  input  wire logic          i_ack_ovf_a,
  input  wire logic          i_ack_ovf_b,
  input  wire logic          i_ack_irq_a,
  input  wire logic          i_ack_irq_b,
  // External pins.
  input  wire logic          i_event_pin_a,
  input  wire logic          i_event_pin_b,
  input  wire logic          i_ext_irq_pin_a_n,
  input  wire logic          i_ext_irq_pin_b_n,
  // Overflow pulses and interrupt requests.
  output logic               o_overflow_pulse_a,
  output logic               o_overflow_pulse_b,
  output logic               o_ovf_flag_a,
  output logic               o_ovf_flag_b,
  output logic               o_ext_irq_flag_a,
  output logic               o_ext_irq_flag_b
);

  function automatic logic wr_at(input tdcu_sfr_req_s r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  function automatic logic src_tick(input logic ct, input logic pre, input logic fall,
                                    input logic fast, input logic slow);
    return ct ? fall : (pre ? fast : slow);
  endfunction

  function automatic tdcu_step_s step(input tdcu_mode_e m, input logic [7:0] th,
                                      input logic [7:0] tl, input logic inc);
    tdcu_step_s s;
    logic [16:0] w;
    s.th  = th;
    s.tl  = tl;
    s.ovf = 1'b0;
    w     = 17'h0;
    if (inc) begin
      unique case (m)
        TDCU_M13: begin
          w     = {4'h0, th, tl[4:0]} + 17'h1;
          s.th  = w[12:5];
          s.tl  = {tl[7:5], w[4:0]};
          s.ovf = w[13];
        end
        TDCU_M16: begin
          w     = {1'b0, th, tl} + 17'h1;
          s.th  = w[15:8];
          s.tl  = w[7:0];
          s.ovf = w[16];
        end
        TDCU_M8R: begin
          w     = {9'h0, tl} + 17'h1;
          s.tl  = w[8] ? th : w[7:0];
          s.ovf = w[8];
        end
        TDCU_SPLIT: begin
          w     = {9'h0, tl} + 17'h1;
          s.tl  = w[7:0];
          s.ovf = w[8];
        end
      endcase
    end
    return s;
  endfunction

  logic [7:0] ctrl_r;
  logic [7:0] mode_r;
  logic [7:0] clk_r;
  logic [7:0] tla_r;
  logic [7:0] tha_r;
  logic [7:0] tlb_r;
  logic [7:0] thb_r;
  logic       pulse_a_r;
  logic       pulse_b_r;
  logic [7:0] rdata_r;

  wire [7:0]  ctrl_nxt;
  wire [7:0]  tla_nxt;
  wire [7:0]  tha_nxt;
  wire [7:0]  tlb_nxt;
  wire [7:0]  thb_nxt;
  wire [7:0]  rdata_nxt;
  wire [8:0]  ha_sum;
  wire [1:0]  ovf_set;
  wire [1:0]  ovf_ack;
  wire [1:0]  irq_ack;

  logic [`TDCU_NPINS-1:0] pin_lvl;
  logic [`TDCU_NPINS-1:0] pin_fall;
  logic                   tick_fast;
  logic                   tick_slow;

  tdcu_pin_sync u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_pins  ({i_ext_irq_pin_b_n, i_ext_irq_pin_a_n, i_event_pin_b, i_event_pin_a}),
    .o_level (pin_lvl),
    .o_fall  (pin_fall)
  );

  tdcu_tick_gen u_ticks (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .o_tick_fast (tick_fast),
    .o_tick_slow (tick_slow)
  );

  wire wr_ctrl = wr_at(i_sfr, `TDCU_A_CTRL);
  wire wr_mode = wr_at(i_sfr, `TDCU_A_MODE);
  wire wr_clk  = wr_at(i_sfr, `TDCU_A_CLK);
  wire wr_tla  = wr_at(i_sfr, `TDCU_A_TLA);
  wire wr_tha  = wr_at(i_sfr, `TDCU_A_THA);
  wire wr_tlb  = wr_at(i_sfr, `TDCU_A_TLB);
  wire wr_thb  = wr_at(i_sfr, `TDCU_A_THB);

  wire tdcu_mode_e mode_a = tdcu_mode_e'(mode_r[`TDCU_F_MODE]);
  wire tdcu_mode_e mode_b = tdcu_mode_e'(mode_r[`TDCU_NIB_B +: 2]);
  wire a_split  = (mode_a == TDCU_SPLIT);
  wire run_a    = ctrl_r[`TDCU_B_RUN_A];
  wire run_b    = ctrl_r[`TDCU_B_RUN_A + `TDCU_STRIDE];
  wire pre_a    = clk_r[`TDCU_B_PRE_A];
  wire pre_b    = clk_r[`TDCU_B_PRE_B];

  wire gate_ok_a = ~mode_r[`TDCU_B_GATE] | pin_lvl[`TDCU_P_IRQ_A];
  wire gate_ok_b = ~mode_r[`TDCU_NIB_B + `TDCU_B_GATE] | pin_lvl[`TDCU_P_IRQ_B];

  wire src_a = src_tick(mode_r[`TDCU_B_CT], pre_a, pin_fall[`TDCU_P_EVT_A],
                        tick_fast, tick_slow);
  wire src_b = src_tick(mode_r[`TDCU_NIB_B + `TDCU_B_CT], pre_b, pin_fall[`TDCU_P_EVT_B],
                        tick_fast, tick_slow);

  // split low byte keeps timer 0 controls
  wire inc_a  = run_a & gate_ok_a & src_a;

  // split high byte uses timer 1 run
  wire inc_ha = a_split & run_b & src_tick(1'b0, pre_a, 1'b0, tick_fast, tick_slow);

  // timer 1 free of run bit only while timer 0 is split
  wire inc_b  = (mode_b != TDCU_SPLIT) & (a_split | run_b) & gate_ok_b & src_b;

  wire tdcu_step_s sa = step(mode_a, tha_r, tla_r, inc_a);
  wire tdcu_step_s sb = step(mode_b, thb_r, tlb_r, inc_b);

  assign ha_sum = {1'b0, tha_r} + 9'h1;

  // Software writes to a count byte take priority over the increment.
  assign tla_nxt = wr_tla ? i_sfr.wdata : sa.tl;
  assign tha_nxt = wr_tha ? i_sfr.wdata :
                   a_split ? (inc_ha ? ha_sum[7:0] : tha_r) : sa.th;
  assign tlb_nxt = wr_tlb ? i_sfr.wdata : sb.tl;
  assign thb_nxt = wr_thb ? i_sfr.wdata : sb.th;

  // high byte sets timer 1 flag
  assign ovf_set = {sb.ovf | (inc_ha & ha_sum[8]), sa.ovf};
  assign ovf_ack = {i_ack_ovf_b, i_ack_ovf_a};
  assign irq_ack = {i_ack_irq_b, i_ack_irq_a};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_flags
      localparam int RB = `TDCU_B_RUN_A + gi * `TDCU_STRIDE;
      localparam int OB = `TDCU_B_OVF_A + gi * `TDCU_STRIDE;
      localparam int TB = `TDCU_B_TYP_A + gi * `TDCU_STRIDE;
      localparam int IB = `TDCU_B_IRQ_A + gi * `TDCU_STRIDE;
      localparam int PI = `TDCU_P_IRQ_A + gi;
      wire ovf_keep = wr_ctrl ? i_sfr.wdata[OB] : ctrl_r[OB];
      wire irq_keep = wr_ctrl ? i_sfr.wdata[IB] : ctrl_r[IB];
      assign ctrl_nxt[RB] = wr_ctrl ? i_sfr.wdata[RB] : ctrl_r[RB];
      assign ctrl_nxt[TB] = wr_ctrl ? i_sfr.wdata[TB] : ctrl_r[TB];
      assign ctrl_nxt[OB] = ovf_set[gi] | (ovf_keep & ~ovf_ack[gi]);
      assign ctrl_nxt[IB] = ctrl_r[TB] ? (pin_fall[PI] | (irq_keep & ~irq_ack[gi]))
                                       : ~pin_lvl[PI];
    end
  endgenerate

  assign o_sfr_sel = (i_sfr.addr == `TDCU_A_CTRL) | (i_sfr.addr == `TDCU_A_MODE) |
                     (i_sfr.addr == `TDCU_A_CLK)  | (i_sfr.addr == `TDCU_A_TLA)  |
                     (i_sfr.addr == `TDCU_A_THA)  | (i_sfr.addr == `TDCU_A_TLB)  |
                     (i_sfr.addr == `TDCU_A_THB);

  // mode 0 upper bits returned unmasked
  assign rdata_nxt = (i_sfr.addr == `TDCU_A_CTRL) ? ctrl_r :
                     (i_sfr.addr == `TDCU_A_MODE) ? mode_r :
                     (i_sfr.addr == `TDCU_A_CLK)  ? clk_r  :
                     (i_sfr.addr == `TDCU_A_TLA)  ? tla_r  :
                     (i_sfr.addr == `TDCU_A_THA)  ? tha_r  :
                     (i_sfr.addr == `TDCU_A_TLB)  ? tlb_r  :
                     (i_sfr.addr == `TDCU_A_THB)  ? thb_r  : 8'h00;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= `TDCU_RST_CTRL;
      mode_r <= `TDCU_RST_MODE;
      clk_r  <= `TDCU_RST_CLK;
    end else begin
      ctrl_r <= ctrl_nxt;
      mode_r <= wr_mode ? i_sfr.wdata : mode_r;
      clk_r  <= wr_clk ? (i_sfr.wdata & `TDCU_CLK_MASK) : clk_r;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tla_r <= `TDCU_RST_CNT;
      tha_r <= `TDCU_RST_CNT;
      tlb_r <= `TDCU_RST_CNT;
      thb_r <= `TDCU_RST_CNT;
    end else begin
      tla_r <= tla_nxt;
      tha_r <= tha_nxt;
      tlb_r <= tlb_nxt;
      thb_r <= thb_nxt;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pulse_a_r <= 1'b0;
      pulse_b_r <= 1'b0;
      rdata_r   <= 8'h00;
    end else begin
      pulse_a_r <= sa.ovf;
      pulse_b_r <= sb.ovf;
      rdata_r   <= rdata_nxt;
    end
  end

  assign o_overflow_pulse_a = pulse_a_r;
  assign o_overflow_pulse_b = pulse_b_r;
  assign o_ovf_flag_a       = ctrl_r[`TDCU_B_OVF_A];
  assign o_ovf_flag_b       = ctrl_r[`TDCU_B_OVF_A + `TDCU_STRIDE];
  assign o_ext_irq_flag_a   = ctrl_r[`TDCU_B_IRQ_A];
  assign o_ext_irq_flag_b   = ctrl_r[`TDCU_B_IRQ_A + `TDCU_STRIDE];
  assign o_sfr_rdata        = rdata_r;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  wire quiet_a = !wr_tla && !wr_tha && !wr_ctrl;
  wire quiet_b = !wr_tlb && !wr_thb && !wr_ctrl;

  sequence wrap13_a;
    inc_a && mode_a == TDCU_M13 && (&{tha_r, tla_r[4:0]}) && quiet_a;
  endsequence

  sequence wrapped_a;
    tla_r[4:0] == 5'h00 && tha_r == 8'h00 && o_ovf_flag_a && o_overflow_pulse_a;
  endsequence

  sequence irq_fall_a;
    ctrl_r[`TDCU_B_TYP_A] && pin_fall[`TDCU_P_IRQ_A] && !i_ack_irq_a;
  endsequence

  mode0_wrap_a: assert property (wrap13_a |=> wrapped_a ##1 !o_overflow_pulse_a)
    else $error("mode 0 wrap did not clear, flag and pulse once");

  mode1_wrap_a: assert property (
    inc_a && mode_a == TDCU_M16 && (&{tha_r, tla_r}) && quiet_a
    |=> {tha_r, tla_r} == 16'h0000 && o_ovf_flag_a && o_overflow_pulse_a)
    else $error("mode 1 wrap misbehaved");

  reload_low_a: assert property (
    inc_a && mode_a == TDCU_M8R && tla_r == 8'hFF && quiet_a
    |=> tla_r == $past(tha_r) && o_overflow_pulse_a)
    else $error("mode 2 reload did not take the high byte");

  gate_hold_a: assert property (
    mode_r[`TDCU_B_GATE] && !pin_lvl[`TDCU_P_IRQ_A] && quiet_a |=> $stable(tla_r))
    else $error("gated timer 0 advanced while its pin was low");

  run_stop_a: assert property (!run_a && quiet_a |=> $stable(tla_r))
    else $error("stopped timer 0 advanced");

  mode3_hold_b: assert property (
    mode_b == TDCU_SPLIT && quiet_b |=> $stable({thb_r, tlb_r}))
    else $error("timer 1 in mode 3 did not hold");

  edge_flag_a: assert property (irq_fall_a |=> o_ext_irq_flag_a)
    else $error("falling edge did not set the interrupt flag");

  level_flag_a: assert property (
    !ctrl_r[`TDCU_B_TYP_A] |=> o_ext_irq_flag_a == !$past(pin_lvl[`TDCU_P_IRQ_A]))
    else $error("level flag does not follow the pin");

  set_wins_a: assert property (sa.ovf && i_ack_ovf_a |=> o_ovf_flag_a)
    else $error("overflow lost against its acknowledge");

  split_high_a: assert property (
    inc_ha && tha_r == 8'hFF && !wr_tha |=> tha_r == 8'h00 && o_ovf_flag_b)
    else $error("split high byte wrap did not set timer 1 flag");

endmodule

// ---- testbench/tdcu_pin_model.sv ----
// Model of the external event, gate and interrupt pins, all idle high.
`timescale 1ns/1ps
module tdcu_pin_model (
  // Clock.
  input  wire logic i_clk,
  // Driven pins.
  output logic      o_event_pin_a,
  output logic      o_event_pin_b,
  output logic      o_ext_irq_pin_a_n,
  output logic      o_ext_irq_pin_b_n
);
  initial begin
    o_event_pin_a     = 1'b1;
    o_event_pin_b     = 1'b1;
    o_ext_irq_pin_a_n = 1'b1;
    o_ext_irq_pin_b_n = 1'b1;
  end

  // one event falls.
  // The low phase outlasts the two-flop synchroniser so the fall is never missed.
  task automatic fall(input int which);
    @(posedge i_clk);
    if (which == 0) o_event_pin_a <= 1'b0; else o_event_pin_b <= 1'b0;
    repeat (4) @(posedge i_clk);
    if (which == 0) o_event_pin_a <= 1'b1; else o_event_pin_b <= 1'b1;
  endtask

  task automatic irq(input int which, input logic lvl);
    @(posedge i_clk);
    if (which == 0) o_ext_irq_pin_a_n <= lvl; else o_ext_irq_pin_b_n <= lvl;
  endtask
endmodule

// ---- testbench/test_tdcu_timer_unit.sv ----
// Self-checking bench for the dual timer/counter unit.
`timescale 1ns/1ps
module test_tdcu_timer_unit;
  import tdcu_pkg::*;
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end

  logic          i_clk;
  logic          i_rst;
  tdcu_sfr_req_s sfr;
  logic          sel;
  logic [7:0]    rdata;
  logic [3:0]    ack;
  logic          ev_a, ev_b, irq_a_n, irq_b_n;
  logic          pls_a, pls_b, ovf_a, ovf_b, eirq_a, eirq_b;
  int            num_errors, num_checks, np_a, np_b;

  tdcu_timer_unit dut (.i_clk(i_clk), .i_rst(i_rst), .i_sfr(sfr), .o_sfr_sel(sel),
    .o_sfr_rdata(rdata), .i_ack_ovf_a(ack[0]), .i_ack_ovf_b(ack[1]),
    .i_ack_irq_a(ack[2]), .i_ack_irq_b(ack[3]), .i_event_pin_a(ev_a),
    .i_event_pin_b(ev_b), .i_ext_irq_pin_a_n(irq_a_n), .i_ext_irq_pin_b_n(irq_b_n),
    .o_overflow_pulse_a(pls_a), .o_overflow_pulse_b(pls_b), .o_ovf_flag_a(ovf_a),
    .o_ovf_flag_b(ovf_b), .o_ext_irq_flag_a(eirq_a), .o_ext_irq_flag_b(eirq_b));

  tdcu_pin_model pins (.i_clk(i_clk), .o_event_pin_a(ev_a), .o_event_pin_b(ev_b),
    .o_ext_irq_pin_a_n(irq_a_n), .o_ext_irq_pin_b_n(irq_b_n));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // Counts clock cycles in which each overflow pulse is high.
  always @(posedge i_clk) begin
    if (pls_a) np_a++;
    if (pls_b) np_b++;
  end

  task automatic wrap_up();
    $display("errors=%0d checks=%0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr_now(input logic [7:0] a, input logic [7:0] d);
    sfr <= '{a, 1'b1, d};
    @(posedge i_clk);
    sfr.wr <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    wr_now(a, d);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge i_clk);
    sfr <= '{a, 1'b0, 8'h00};
    @(posedge i_clk);
    @(negedge i_clk);
    `CHK(rdata & m, e)
  endtask

  task automatic pulse_ack(input int i);
    @(posedge i_clk);
    ack[i] <= 1'b1;
    @(posedge i_clk);
    ack[i] <= 1'b0;
    @(negedge i_clk);
  endtask

  // Returns at the edge that first sees the pulse, one edge after the wrap.
  task automatic wait_pls(input int b, output int cyc);
    cyc = 0;
    do begin
      @(posedge i_clk);
      cyc++;
    end while (!(b ? pls_b : pls_a) && cyc < 300);
    if (cyc >= 300) `CHK(cyc, 0)
  endtask

  task automatic s_reset();
    logic [7:0] rv [7];
    rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    for (int i = 0; i < 7; i++) chk_rd(8'(8'h88 + i), 8'hFF, rv[i]);
    chk_rd(8'h8F, 8'hFF, 8'h00);
    `CHK(sel, 1'b0)
    wr(8'h8E, 8'hFF);
    chk_rd(8'h8E, 8'hFF, 8'h3F);
    `CHK(sel, 1'b1)
  endtask

  task automatic s_rate();
    int c;
    for (int t = 0; t < 2; t++) begin
      for (int p = 0; p < 2; p++) begin
        wr(8'h89, t ? 8'h20 : 8'h02);
        wr(t ? 8'h8B : 8'h8A, 8'hFE);
        wr(t ? 8'h8D : 8'h8C, 8'hFE);
        wr(8'h8E, p ? (t ? 8'h10 : 8'h08) : 8'h00);
        wr(8'h88, t ? 8'h40 : 8'h10);
        wait_pls(t, c);
        wait_pls(t, c);
        `CHK(t ? ovf_b : ovf_a, 1'b1)
        wr_now(8'h88, 8'h00);
        `CHK(c, p ? 8 : 24)
        chk_rd(t ? 8'h8B : 8'h8A, 8'hFF, 8'hFE);
        `CHK(t ? ovf_b : ovf_a, 1'b0)
      end
    end
  endtask

  task automatic s_event();
    int n0;
    wr(8'h89, 8'h45);
    wr(8'h8A, 8'hFF);
    wr(8'h8C, 8'hFF);
    wr(8'h8B, 8'hFF);
    wr(8'h8D, 8'hFF);
    wr(8'h8E, 8'h08);
    wr(8'h88, 8'h50);
    n0 = np_a;
    pins.fall(0);
    repeat (3) @(posedge i_clk);
    `CHK(np_a - n0, 1)
    `CHK(ovf_a, 1'b1)
    chk_rd(8'h8A, 8'hFF, 8'h00);
    chk_rd(8'h8C, 8'hFF, 8'h00);
    pulse_ack(0);
    `CHK(ovf_a, 1'b0)
    pins.fall(0);
    repeat (3) @(posedge i_clk);
    chk_rd(8'h8A, 8'hFF, 8'h01);
    n0 = np_b;
    pins.fall(1);
    repeat (3) @(posedge i_clk);
    `CHK(np_b - n0, 1)
    `CHK(ovf_b, 1'b1)
    chk_rd(8'h8D, 8'hFF, 8'h00);
    chk_rd(8'h8B, 8'h1F, 8'h00);
    pulse_ack(1);
    `CHK(ovf_b, 1'b0)
    wr(8'h88, 8'h00);
  endtask

  task automatic s_gate_level();
    wr(8'h89, 8'h0D);
    wr(8'h8A, 8'h00);
    wr(8'h8C, 8'h00);
    wr(8'h88, 8'h10);
    pins.irq(0, 1'b0);
    repeat (5) @(posedge i_clk);
    `CHK(eirq_a, 1'b1)
    wr(8'h88, 8'h10);
    @(negedge i_clk);
    `CHK(eirq_a, 1'b1)
    pulse_ack(2);
    `CHK(eirq_a, 1'b1)
    pins.fall(0);
    repeat (3) @(posedge i_clk);
    chk_rd(8'h8A, 8'hFF, 8'h00);
    pins.irq(0, 1'b1);
    repeat (5) @(posedge i_clk);
    `CHK(eirq_a, 1'b0)
    pins.fall(0);
    repeat (3) @(posedge i_clk);
    chk_rd(8'h8A, 8'hFF, 8'h01);
    wr(8'h88, 8'h00);
  endtask

  task automatic s_edge();
    wr(8'h88, 8'h04);
    pins.irq(1, 1'b0);
    repeat (5) @(posedge i_clk);
    `CHK(eirq_b, 1'b1)
    pins.irq(1, 1'b1);
    pulse_ack(3);
    `CHK(eirq_b, 1'b0)
    pins.irq(1, 1'b0);
    repeat (5) @(posedge i_clk);
    `CHK(eirq_b, 1'b1)
    wr(8'h88, 8'h04);
    @(negedge i_clk);
    `CHK(eirq_b, 1'b0)
    pins.irq(1, 1'b1);
  endtask

  task automatic s_split();
    int c;
    int n0;
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h33);
    wr(8'h8C, 8'hFF);
    wr(8'h8B, 8'h10);
    wr(8'h8E, 8'h08);
    n0 = np_b;
    wr(8'h88, 8'h40);
    c = 0;
    do begin
      @(posedge i_clk);
      c++;
    end while (!ovf_b && c < 40);
    `CHK(ovf_b, 1'b1)
    wr_now(8'h88, 8'h00);
    `CHK(np_b - n0, 0)
    chk_rd(8'h8C, 8'hFF, 8'h00);
    chk_rd(8'h8B, 8'hFF, 8'h10);
    `CHK(c <= 6, 1'b1)
    // Timer 1 must run in mode 2 with its run bit clear while timer 0 is split.
    wr(8'h89, 8'h23);
    repeat (30) @(posedge i_clk);
    wr(8'h89, 8'h33);
    chk_rd(8'h8B, 8'h00, 8'h00);
    `CHK(rdata != 8'h10, 1'b1)
  endtask

  initial begin
    num_errors = 0;
    num_checks = 0;
    np_a = 0;
    np_b = 0;
    sfr = '0;
    ack = '0;
    i_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    s_reset();
    s_rate();
    s_event();
    s_gate_level();
    s_edge();
    s_split();
    wrap_up();
  end

  initial begin
    #400000;
    num_errors++;
    wrap_up();
  end
endmodule
